/* rtl/otl_axis_overtravel.sv */
// Per-axis overtravel limit logic with an APB register slave.
`timescale 1ns/1ps
`default_nettype none
module otl_axis_overtravel
  import otl_pkg::*;
#(
  parameter logic [15:0] STOP_RST = 16'h0000
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Limit switch pins.
  input wire logic fwd_limit_input,
  input wire logic rev_limit_input,
  // Drive state.
  input wire logic cmd_fwd,
  input wire logic cmd_rev,
  input wire logic motor_stopped,
  input wire logic [9:0] motor_max_torque,
  // Stop control towards the power stage.
  output logic allow_fwd,
  output logic allow_rev,
  output otl_act_e stop_action,
  output otl_hold_e hold_state,
  output logic zero_clamp,
  output logic [9:0] stop_torque,
  output logic [9:0] stop_torque_b,
  output logic [15:0] limit_warning_code,
  output logic alarm
);

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  // Clip a torque to the motor maximum.
  function automatic logic [9:0] clip_trq(input logic [9:0] t, input logic [9:0] mx);
    clip_trq = (t > mx) ? mx : t;
  endfunction : clip_trq

  // ----------------------------------------------------------------
  // Limit input synchronisers.
  // ----------------------------------------------------------------
  logic [1:0] fwd_sync, rev_sync;
  logic [1:0] next_fwd_sync, next_rev_sync;

  // Two stages so a bouncing switch cannot reach the logic metastable.
  always_comb begin
    next_fwd_sync = {fwd_sync[0], fwd_limit_input};
    next_rev_sync = {rev_sync[0], rev_limit_input};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fwd_sync <= 2'b11;
      rev_sync <= 2'b11;
    end else begin
      fwd_sync <= next_fwd_sync;
      rev_sync <= next_rev_sync;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic [15:0] src_cfg, stop_cfg, warn_cfg, src_act, stop_act, warn_act;
  logic [3:0] mask_cfg;
  logic [9:0] estop_trq, spa_trq, spb_trq;
  logic spindle, torque_ctrl, warn_flag;
  logic [15:0] next_src_cfg, next_stop_cfg, next_warn_cfg, next_src_act, next_stop_act;
  logic [15:0] next_warn_act;
  logic [3:0] next_mask_cfg;
  logic [9:0] next_estop_trq, next_spa_trq, next_spb_trq;
  logic next_spindle, next_torque_ctrl, next_warn_flag;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic acc, wr, hit;
  logic fwd_ot, rev_ot;

  // Register file decode; the slave answers one cycle after the access phase starts.
  // A write lands only at the edge that completes the transfer, as the master sees it.
  always_comb begin
    acc = psel && penable && !pready;
    wr = psel && penable && pready && pwrite;
    next_src_cfg = src_cfg;
    next_stop_cfg = stop_cfg;
    next_warn_cfg = warn_cfg;
    next_mask_cfg = mask_cfg;
    next_estop_trq = estop_trq;
    next_spa_trq = spa_trq;
    next_spb_trq = spb_trq;
    next_spindle = spindle;
    next_torque_ctrl = torque_ctrl;
    next_src_act = src_act;
    next_stop_act = stop_act;
    next_warn_act = warn_act;
    next_prdata = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr)
      OTL_SOURCE_CFG: begin
        next_prdata = {16'h0000, src_cfg};
        if (wr) next_src_cfg = pwdata[15:0];
      end
      OTL_STOP_CFG: begin
        next_prdata = {16'h0000, stop_cfg};
        if (wr) next_stop_cfg = pwdata[15:0];
      end
      OTL_WARN_CFG: begin
        next_prdata = {16'h0000, warn_cfg};
        if (wr) next_warn_cfg = pwdata[15:0];
      end
      OTL_MASK_CFG: begin
        next_prdata = {28'h000_0000, mask_cfg};
        if (wr) next_mask_cfg = pwdata[3:0];
      end
      OTL_ESTOP_TRQ: begin
        next_prdata = {22'h00_0000, estop_trq};
        // Values above the range are refused and the old setting stays.
        if (wr && pwdata[31:0] <= {22'h00_0000, OTL_TRQ_MAX}) next_estop_trq = pwdata[9:0];
      end
      OTL_SPINDLE_TRQ: begin
        next_prdata = {6'h00, spb_trq, 6'h00, spa_trq};
        if (wr && pwdata[9:0] <= OTL_TRQ_MAX) next_spa_trq = pwdata[9:0];
        if (wr && pwdata[25:16] <= OTL_TRQ_MAX) next_spb_trq = pwdata[25:16];
      end
      OTL_CTRL: begin
        next_prdata = {29'h0000_0000, torque_ctrl, spindle, 1'b0};
        if (wr) begin
          next_spindle = pwdata[OTL_CTRL_SPINDLE];
          next_torque_ctrl = pwdata[OTL_CTRL_TORQUE];
          if (pwdata[OTL_CTRL_RESTART]) begin
            next_src_act = src_cfg;
            next_stop_act = stop_cfg;
            next_warn_act = warn_cfg;
          end
        end
      end
      OTL_SERVO_IO: next_prdata = {28'h000_0000, rev_ot, fwd_ot, 2'b00};
      OTL_CMD_STAT: next_prdata = {30'h0000_0000, warn_flag, 1'b0};
      OTL_WARN_CODE: next_prdata = {16'h0000, limit_warning_code};
      OTL_STATE: next_prdata = {26'h000_0000, hold_state, stop_action, zero_clamp, alarm};
      default: hit = 1'b0;
    endcase
    if (!acc) next_prdata = 32'h0000_0000;
    next_pready = acc;
    next_pslverr = acc && !hit;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_cfg <= OTL_SOURCE_RST;
      stop_cfg <= STOP_RST;
      warn_cfg <= OTL_WARN_RST;
      src_act <= OTL_SOURCE_RST;
      stop_act <= STOP_RST;
      warn_act <= OTL_WARN_RST;
      mask_cfg <= OTL_MASK_RST;
      estop_trq <= OTL_TRQ_MAX;
      spa_trq <= OTL_TRQ_MAX;
      spb_trq <= OTL_TRQ_MAX;
      spindle <= 1'b0;
      torque_ctrl <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      src_cfg <= next_src_cfg;
      stop_cfg <= next_stop_cfg;
      warn_cfg <= next_warn_cfg;
      src_act <= next_src_act;
      stop_act <= next_stop_act;
      warn_act <= next_warn_act;
      mask_cfg <= next_mask_cfg;
      estop_trq <= next_estop_trq;
      spa_trq <= next_spa_trq;
      spb_trq <= next_spb_trq;
      spindle <= next_spindle;
      torque_ctrl <= next_torque_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Overtravel detection, stop sequencing and outputs.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OTL_RUN, OTL_STOPPING, OTL_HOLD} otl_state_e;
  otl_state_e state, next_state;
  otl_act_e act, next_stop_action;
  otl_hold_e hold, next_hold_state;
  logic fwd_en, rev_en, ot_any, ot_new, back_cmd, w1c;
  logic next_allow_fwd, next_allow_rev, next_zero_clamp, next_fwd_ot, next_rev_ot;
  logic [9:0] next_stop_torque, next_stop_torque_b;
  logic [15:0] next_warn_code;

  // A limit counts only when its source takes the input and the mask leaves it on.
  always_comb begin
    fwd_en = (src_act[15:12] != OTL_SRC_IGNORE) && !mask_cfg[0];
    rev_en = (src_act[3:0] != OTL_SRC_IGNORE) && !mask_cfg[1];
    next_fwd_ot = fwd_en && !fwd_sync[1];
    next_rev_ot = rev_en && !rev_sync[1];
    ot_any = next_fwd_ot || next_rev_ot;
    ot_new = (next_fwd_ot && !fwd_ot) || (next_rev_ot && !rev_ot);
    // Commanded motion away from the tripped limit releases the stop.
    back_cmd = (fwd_ot && cmd_rev && !cmd_fwd) || (rev_ot && cmd_fwd && !cmd_rev);
    // Pick the stop method; torque control and spindle override the field.
    if (spindle) begin
      act = OTL_ACT_COAST;
      hold = OTL_HOLD_COAST;
    end else if (stop_act[7:4] != 4'h0 && !torque_ctrl) begin
      act = OTL_ACT_DECEL;
      hold = (stop_act[7:4] == 4'h1) ? OTL_HOLD_CLAMP : OTL_HOLD_COAST;
    end else if (stop_act[3:0] == 4'h2) begin
      act = OTL_ACT_COAST;
      hold = OTL_HOLD_COAST;
    end else begin
      act = OTL_ACT_DBRAKE;
      // Torque control always ends in coasting, whatever brake state the field asks for.
      hold = (stop_act[3:0] == 4'h0 && stop_act[7:4] == 4'h0 && !torque_ctrl) ? OTL_HOLD_DBRAKE
                                                                : OTL_HOLD_COAST;
    end
    next_state = state;
    next_stop_action = stop_action;
    next_hold_state = hold_state;
    unique case (state)
      OTL_RUN: begin
        next_stop_action = OTL_ACT_NONE;
        if (ot_new) begin
          next_state = OTL_STOPPING;
          next_stop_action = act;
          next_hold_state = hold;
        end
      end
      OTL_STOPPING: begin
        if (!ot_any || back_cmd) begin
          next_state = OTL_RUN;
          next_stop_action = OTL_ACT_NONE;
        end else if (motor_stopped) begin
          next_state = OTL_HOLD;
          next_stop_action = OTL_ACT_NONE;
        end
      end
      OTL_HOLD: begin
        if (!ot_any || back_cmd) next_state = OTL_RUN;
      end
    endcase
    // Zero clamp closes the position loop on a zero reference while holding.
    next_zero_clamp = (next_state == OTL_HOLD) && (next_hold_state == OTL_HOLD_CLAMP);
    next_allow_fwd = !next_fwd_ot;
    next_allow_rev = !next_rev_ot;
    if (spindle) begin
      next_stop_torque = clip_trq(spa_trq, motor_max_torque);
      next_stop_torque_b = clip_trq(spb_trq, motor_max_torque);
    end else begin
      next_stop_torque = clip_trq(estop_trq, motor_max_torque);
      next_stop_torque_b = next_stop_torque;
    end
    next_warn_code = (warn_act[15:12] == OTL_WARN_ENABLE && ot_any) ? OTL_LIMIT_WARN_CODE
                                                                     : 16'h0000;
    // Hardware set wins over a software clear in the same cycle.
    w1c = wr && paddr == OTL_CMD_STAT && pwdata[OTL_WARN_BIT];
    next_warn_flag = (next_warn_code != 16'h0000) || (warn_flag && !w1c);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= OTL_RUN;
      stop_action <= OTL_ACT_NONE;
      hold_state <= OTL_HOLD_COAST;
      zero_clamp <= 1'b0;
      allow_fwd <= 1'b1;
      allow_rev <= 1'b1;
      fwd_ot <= 1'b0;
      rev_ot <= 1'b0;
      stop_torque <= 10'd0;
      stop_torque_b <= 10'd0;
      limit_warning_code <= 16'h0000;
      warn_flag <= 1'b0;
      alarm <= 1'b0;
    end else begin
      state <= next_state;
      stop_action <= next_stop_action;
      hold_state <= next_hold_state;
      zero_clamp <= next_zero_clamp;
      allow_fwd <= next_allow_fwd;
      allow_rev <= next_allow_rev;
      fwd_ot <= next_fwd_ot;
      rev_ot <= next_rev_ot;
      stop_torque <= next_stop_torque;
      stop_torque_b <= next_stop_torque_b;
      limit_warning_code <= next_warn_code;
      warn_flag <= next_warn_flag;
      alarm <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  a_fwd_block: assert property (@(posedge clk_sys) disable iff (rst)
    (!fwd_sync[1] && fwd_en) |=> !allow_fwd) else $error("forward not blocked");
  a_rev_block: assert property (@(posedge clk_sys) disable iff (rst)
    (!rev_sync[1] && rev_en) |=> !allow_rev) else $error("reverse not blocked");
  a_opposite_allowed: assert property (@(posedge clk_sys) disable iff (rst)
    (fwd_ot && rev_sync[1]) |=> allow_rev) else $error("opposite motion blocked");
  a_mask_fwd: assert property (@(posedge clk_sys) disable iff (rst)
    mask_cfg[0] |=> allow_fwd) else $error("masked forward still blocks");
  a_spindle_coast: assert property (@(posedge clk_sys) disable iff (rst)
    (state == OTL_RUN && ot_new && spindle) |=> stop_action == OTL_ACT_COAST)
    else $error("spindle not coasting");
  a_torque_nodecel: assert property (@(posedge clk_sys) disable iff (rst)
    (state == OTL_RUN && ot_new && torque_ctrl) |=> stop_action != OTL_ACT_DECEL)
    else $error("decel under torque control");
  a_torque_clip: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 stop_torque <= $past(motor_max_torque)) else $error("stop torque above max");
  a_status_bits: assert property (@(posedge clk_sys) disable iff (rst)
    (acc && !pwrite && paddr == OTL_SERVO_IO) |=>
    (prdata[3] == $past(rev_ot) && prdata[2] == $past(fwd_ot)))
    else $error("status bits wrong");
  a_warn_set: assert property (@(posedge clk_sys) disable iff (rst)
    (ot_any && warn_act[15:12] == OTL_WARN_ENABLE) |=> warn_flag && limit_warning_code != 0)
    else $error("warning not raised");
  a_clamp_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (state == OTL_STOPPING && motor_stopped && ot_any && !back_cmd
     && hold_state == OTL_HOLD_CLAMP) |=> zero_clamp) else $error("no zero clamp");
  a_no_alarm: assert property (@(posedge clk_sys) disable iff (rst)
    fwd_ot |-> !alarm) else $error("alarm on overtravel");

endmodule : otl_axis_overtravel
`default_nettype wire

/* pkg/otl_pkg.sv */
// Package with register map, field layout, reset values and codes of the overtravel logic.
package otl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] OTL_SOURCE_CFG = 8'h00;
  localparam logic [7:0] OTL_STOP_CFG = 8'h04;
  localparam logic [7:0] OTL_WARN_CFG = 8'h08;
  localparam logic [7:0] OTL_MASK_CFG = 8'h0C;
  localparam logic [7:0] OTL_ESTOP_TRQ = 8'h10;
  localparam logic [7:0] OTL_SPINDLE_TRQ = 8'h14;
  localparam logic [7:0] OTL_CTRL = 8'h18;
  localparam logic [7:0] OTL_SERVO_IO = 8'h1C;
  localparam logic [7:0] OTL_CMD_STAT = 8'h20;
  localparam logic [7:0] OTL_WARN_CODE = 8'h24;
  localparam logic [7:0] OTL_STATE = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and digit values.
  // ----------------------------------------------------------------
  localparam int OTL_FWD_OT_BIT = 2;
  localparam int OTL_REV_OT_BIT = 3;
  localparam int OTL_WARN_BIT = 1;
  localparam int OTL_CTRL_RESTART = 0;
  localparam int OTL_CTRL_SPINDLE = 1;
  localparam int OTL_CTRL_TORQUE = 2;
  localparam logic [3:0] OTL_SRC_FWD_INPUT = 4'h1;
  localparam logic [3:0] OTL_SRC_REV_INPUT = 4'h2;
  localparam logic [3:0] OTL_SRC_IGNORE = 4'h8;
  localparam logic [3:0] OTL_WARN_ENABLE = 4'h1;

  // ----------------------------------------------------------------
  // Reset values and limits.
  // ----------------------------------------------------------------
  localparam logic [15:0] OTL_SOURCE_RST = 16'h1002;
  localparam logic [15:0] OTL_WARN_RST = 16'h0000;
  localparam logic [3:0] OTL_MASK_RST = 4'h0;
  localparam logic [9:0] OTL_TRQ_MAX = 10'd800;
  localparam logic [15:0] OTL_LIMIT_WARN_CODE = 16'h09A0;

  // ----------------------------------------------------------------
  // Stop actions and the state kept after the stop.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OTL_ACT_NONE, OTL_ACT_DBRAKE, OTL_ACT_COAST, OTL_ACT_DECEL} otl_act_e;
  typedef enum logic [1:0] {OTL_HOLD_DBRAKE, OTL_HOLD_COAST, OTL_HOLD_CLAMP} otl_hold_e;

endpackage : otl_pkg

/* bench/otl_host_model.sv */
// Host controller model that commands motion and reports motor standstill.
`timescale 1ns/1ps
`default_nettype none
module otl_host_model
  import otl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the bench.
  input wire logic go_fwd,
  input wire logic go_back,
  // Drive state seen by the host.
  input wire logic allow_fwd,
  input wire logic allow_rev,
  input wire otl_act_e stop_action,
  // Motion towards the drive.
  output logic cmd_fwd,
  output logic cmd_rev,
  output logic motor_stopped
);
  logic [2:0] settle;

  // The feed halts once forward motion is forbidden, and the return move runs only while tripped.
  // Standstill is reported a few cycles into a stop, so the stop method is visible first.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_fwd <= 1'b0;
      cmd_rev <= 1'b0;
      motor_stopped <= 1'b0;
      settle <= 3'h0;
    end else begin
      cmd_fwd <= go_fwd && allow_fwd;
      cmd_rev <= go_back && !allow_fwd;
      if (cmd_fwd || cmd_rev || (allow_fwd && allow_rev)) begin
        motor_stopped <= 1'b0;
        settle <= 3'h0;
      end else if (stop_action != OTL_ACT_NONE) begin
        if (settle == 3'h5) motor_stopped <= 1'b1;
        else settle <= settle + 3'h1;
      end
    end
  end
endmodule : otl_host_model
`default_nettype wire

/* bench/otl_axis_overtravel_tb.sv */
// Self-checking testbench of the per-axis overtravel logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module otl_axis_overtravel_tb
  import otl_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, cmd_fwd, cmd_rev, motor_stopped, zero_clamp, alarm;
  logic fwd_pin = 1'b1, rev_pin = 1'b1, go_fwd = 1'b0, go_back = 1'b0, allow_fwd, allow_rev;
  logic [9:0] max_trq = 10'h384, stop_torque, stop_torque_b;
  logic [15:0] warn_code;
  otl_act_e stop_action;
  otl_hold_e hold_state;
  int fail_count = 0, checks = 0;
  // Stop method table: config, mode {torque, spindle}, expected action and after-stop state.
  logic [7:0] cfg[9] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h10, 8'h12, 8'h10, 8'h00};
  logic [1:0] mode[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h2};
  otl_act_e sact[9] = '{OTL_ACT_DBRAKE, OTL_ACT_DBRAKE, OTL_ACT_COAST, OTL_ACT_DECEL,
    OTL_ACT_DECEL, OTL_ACT_DBRAKE, OTL_ACT_COAST, OTL_ACT_COAST, OTL_ACT_DBRAKE};
  otl_hold_e shold[9] = '{OTL_HOLD_DBRAKE, OTL_HOLD_COAST, OTL_HOLD_COAST, OTL_HOLD_CLAMP,
    OTL_HOLD_COAST, OTL_HOLD_COAST, OTL_HOLD_COAST, OTL_HOLD_COAST, OTL_HOLD_COAST};

  // A 200 MHz clock.
  always #2.5 clk_sys = ~clk_sys;

  otl_axis_overtravel i_otl_axis_overtravel (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fwd_limit_input(fwd_pin), .rev_limit_input(rev_pin),
    .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev), .motor_stopped(motor_stopped),
    .motor_max_torque(max_trq), .allow_fwd(allow_fwd), .allow_rev(allow_rev),
    .stop_action(stop_action), .hold_state(hold_state), .zero_clamp(zero_clamp),
    .stop_torque(stop_torque), .stop_torque_b(stop_torque_b),
    .limit_warning_code(warn_code), .alarm(alarm));

  otl_host_model i_otl_host_model (.clk_sys(clk_sys), .rst(rst), .go_fwd(go_fwd),
    .go_back(go_back), .allow_fwd(allow_fwd), .allow_rev(allow_rev),
    .stop_action(stop_action), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev),
    .motor_stopped(motor_stopped));

  // ----------------------------------------------------------------
  // Bus cycles, waits and the closing report.
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // One APB transfer; data and error are taken at the edge that sees pready high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH apb_ready exp 1 got %0h", pready);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic restart(input logic [1:0] md);
    apb(1'b1, OTL_CTRL, {29'h0, md, 1'b1});
  endtask : restart

  function automatic logic pick(input int s);
    case (s)
      0: return allow_fwd;
      1: return allow_rev;
      2: return stop_action == OTL_ACT_NONE;
      default: return zero_clamp;
    endcase
  endfunction : pick

  // Bounded wait for an output level; running out ends the run as a failure.
  task automatic wait_for(input int s, input logic v);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (pick(s) === v) break;
    end
    if (n == 50) begin
      fail_count++;
      $display("MISMATCH wait %0d exp %0h got %0h", s, v, pick(s));
      finish_test();
    end
  endtask : wait_for

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OTL_SOURCE_CFG, 32'h0);
    `CHK("source_cfg", 32'h0000_1002, rd)
    apb(1'b0, OTL_ESTOP_TRQ, 32'h0);
    `CHK("estop_trq", 32'h0000_0320, rd)
    apb(1'b0, OTL_SPINDLE_TRQ, 32'h0);
    `CHK("spindle_trq", 32'h0320_0320, rd)
    `CHK("stop_torque", 10'h320, stop_torque)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    $display("test reset done");
  endtask : t_reset

  // Forward trip with decelerate-and-clamp, then a return move clears it.
  task automatic t_fwd();
    apb(1'b1, OTL_STOP_CFG, 32'h0000_0010);
    restart(2'h0);
    go_fwd <= 1'b1;
    fwd_pin <= 1'b0;
    wait_for(0, 1'b0);
    `CHK("allow_rev", 1'b1, allow_rev)
    `CHK("alarm", 1'b0, alarm)
    wait_for(2, 1'b1);
    `CHK("zero_clamp", 1'b1, zero_clamp)
    apb(1'b0, OTL_SERVO_IO, 32'h0);
    `CHK("servo_io", 32'h0000_0004, rd)
    go_back <= 1'b1;
    wait_for(3, 1'b0);
    `CHK("stop_action", OTL_ACT_NONE, stop_action)
    fwd_pin <= 1'b1;
    go_back <= 1'b0;
    go_fwd <= 1'b0;
    wait_for(0, 1'b1);
    apb(1'b0, OTL_SERVO_IO, 32'h0);
    `CHK("servo_io", 32'h0000_0000, rd)
    $display("test forward done");
  endtask : t_fwd

  task automatic t_rev_warn();
    apb(1'b1, OTL_WARN_CFG, 32'h0000_1000);
    restart(2'h0);
    rev_pin <= 1'b0;
    wait_for(1, 1'b0);
    `CHK("allow_fwd", 1'b1, allow_fwd)
    apb(1'b0, OTL_SERVO_IO, 32'h0);
    `CHK("servo_io", 32'h0000_0008, rd)
    apb(1'b0, OTL_CMD_STAT, 32'h0);
    `CHK("warn_flag", 1'b1, rd[OTL_WARN_BIT])
    apb(1'b0, OTL_WARN_CODE, 32'h0);
    `CHK("warn_code", 32'h0000_09a0, rd)
    `CHK("warn_port", 16'h09a0, warn_code)
    rev_pin <= 1'b1;
    wait_for(1, 1'b1);
    apb(1'b1, OTL_CMD_STAT, 32'h0000_0002);
    apb(1'b0, OTL_CMD_STAT, 32'h0);
    `CHK("warn_flag", 1'b0, rd[OTL_WARN_BIT])
    `CHK("warn_port", 16'h0000, warn_code)
    apb(1'b1, OTL_WARN_CFG, 32'h0000_0000);
    restart(2'h0);
    $display("test warning done");
  endtask : t_rev_warn

  // Every value of mask bits 0 and 1, with both switches open; the mask acts without restart.
  task automatic t_mask();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OTL_MASK_CFG, 32'(m));
      fwd_pin <= 1'b0;
      rev_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      `CHK("mask_fwd", m[0], allow_fwd)
      `CHK("mask_rev", m[1], allow_rev)
      fwd_pin <= 1'b1;
      rev_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    apb(1'b1, OTL_MASK_CFG, 32'h0000_0000);
    $display("test mask done");
  endtask : t_mask

  // Ignore setting must wait for a restart before it applies.
  task automatic t_source();
    apb(1'b1, OTL_SOURCE_CFG, 32'h0000_8008);
    fwd_pin <= 1'b0;
    wait_for(0, 1'b0);
    apb(1'b0, OTL_SERVO_IO, 32'h0);
    `CHK("pre_restart", 32'h0000_0004, rd)
    fwd_pin <= 1'b1;
    wait_for(0, 1'b1);
    restart(2'h0);
    fwd_pin <= 1'b0;
    rev_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK("ignore_fwd", 1'b1, allow_fwd)
    `CHK("ignore_rev", 1'b1, allow_rev)
    fwd_pin <= 1'b1;
    rev_pin <= 1'b1;
    apb(1'b1, OTL_SOURCE_CFG, 32'h0000_1002);
    restart(2'h0);
    $display("test source done");
  endtask : t_source

  task automatic t_stop();
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, OTL_STOP_CFG, {24'h0, cfg[i]});
      restart(mode[i]);
      fwd_pin <= 1'b0;
      wait_for(0, 1'b0);
      `CHK("stop_action", sact[i], stop_action)
      `CHK("hold_state", shold[i], hold_state)
      wait_for(2, 1'b1);
      `CHK("zero_clamp", shold[i] == OTL_HOLD_CLAMP, zero_clamp)
      fwd_pin <= 1'b1;
      wait_for(0, 1'b1);
    end
    restart(2'h0);
    $display("test stop done");
  endtask : t_stop

  task automatic t_torque();
    max_trq <= 10'h12c;
    apb(1'b1, OTL_ESTOP_TRQ, 32'h0000_01f4);
    repeat (2) @(posedge clk_sys);
    `CHK("clip", 10'h12c, stop_torque)
    max_trq <= 10'h384;
    apb(1'b1, OTL_ESTOP_TRQ, 32'h0000_0321);
    apb(1'b0, OTL_ESTOP_TRQ, 32'h0);
    `CHK("estop_trq", 32'h0000_01f4, rd)
    `CHK("stop_torque", 10'h1f4, stop_torque)
    apb(1'b1, OTL_SPINDLE_TRQ, 32'h00c8_0064);
    restart(2'h1);
    repeat (2) @(posedge clk_sys);
    `CHK("spindle_a", 10'h064, stop_torque)
    `CHK("spindle_b", 10'h0c8, stop_torque_b)
    restart(2'h0);
    $display("test torque done");
  endtask : t_torque

  // Reset for ten cycles, then run every scenario.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_fwd();
    t_rev_warn();
    t_mask();
    t_source();
    t_stop();
    t_torque();
    finish_test();
  end
endmodule : otl_axis_overtravel_tb
`default_nettype wire
